//--- design/fps_pkg.sv
// ****************************************************************
// constants, types and helpers of the flash sequencer
// ****************************************************************
package fps_pkg;

  // ****************************************************************
  // register map (byte addresses) and field positions
  // ****************************************************************
  localparam int          APB_AW         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_KEY       = 8'h04;
  localparam logic [7:0]  ADDR_TABLE_PAGE_REG    = 8'h08;
  localparam logic [7:0]  ADDR_TBLOFS    = 8'h0C;
  localparam logic [7:0]  ADDR_TBLDAT    = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;

  localparam int          CTRL_TRIG_BIT  = 15;
  localparam int          CTRL_ALLOW_BIT = 14;
  localparam int          CTRL_FAULT_BIT = 13;
  localparam int          CTRL_ERASE_BIT = 6;
  localparam int          CTRL_OPSEL_LSB = 0;
  localparam int          OPSEL_W        = 4;

  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_KEY_LSB   = 1;
  localparam int          STAT_FILL_LSB  = 8;

  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;

  // ****************************************************************
  // operation-select codes
  // ****************************************************************
  localparam logic [3:0]  OPC_BULK       = 4'hF;
  localparam logic [3:0]  OPC_GSEG       = 4'hD;
  localparam logic [3:0]  OPC_SSEG       = 4'hC;
  localparam logic [3:0]  OPC_PAGE       = 4'h2;
  localparam logic [3:0]  OPC_CFG        = 4'h0;
  localparam logic [3:0]  OPC_WORD       = 4'h3;
  localparam logic [3:0]  OPC_ROW        = 4'h1;

  // ****************************************************************
  // geometry: addresses count two units per instruction
  // ****************************************************************
  localparam int          ROW_WORDS      = 64;
  localparam int          PM_AW          = 24;
  localparam int          PM_DW          = 24;
  localparam logic [23:0] PAGE_MASK      = 24'hFFFC00;
  localparam logic [23:0] ROW_MASK       = 24'hFFFF80;

  // ****************************************************************
  // timing: counts of the internal fast oscillator, scaled to core_clk
  // ****************************************************************
  localparam longint      CORE_CLK_KHZ    = 25000;
  localparam longint      FAST_OSC_KHZ    = 7370;
  localparam longint      ROW_OSC_CYCLES  = 11064;
  localparam longint      WORD_OSC_CYCLES = 400;
  localparam longint      PAGE_OSC_CYCLES = 12000;
  localparam longint      BULK_OSC_CYCLES = 80000;

  function automatic int osc_to_core(input longint n);
    osc_to_core = int'((n * CORE_CLK_KHZ + FAST_OSC_KHZ - 1) / FAST_OSC_KHZ);
  endfunction

  localparam int          ROW_CORE_CYCLES  = osc_to_core(ROW_OSC_CYCLES);
  localparam int          WORD_CORE_CYCLES = osc_to_core(WORD_OSC_CYCLES);
  localparam int          PAGE_CORE_CYCLES = osc_to_core(PAGE_OSC_CYCLES);
  localparam int          BULK_CORE_CYCLES = osc_to_core(BULK_OSC_CYCLES);
  localparam int          TMR_W            = 24;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fps_key_e;
  typedef enum logic {ST_IDLE, ST_RUN} fps_state_e;
  typedef enum logic [3:0] {
    OP_NONE, OP_BULK, OP_GSEG, OP_SSEG, OP_PAGE, OP_CFG_ERASE,
    OP_WORD, OP_ROW, OP_CFG_PROG
  } fps_op_e;

  typedef struct packed {
    logic             start;
    fps_op_e          op;
    logic [PM_AW-1:0] addr;
    logic [PM_DW-1:0] word;
  } fps_flash_cmd_s;

  typedef struct packed {
    logic             valid;
    logic [5:0]       idx;
    logic [PM_DW-1:0] data;
  } fps_row_beat_s;

endpackage

//--- design/fps_row_buffer.sv
`timescale 1ns/10ps
// ****************************************************************
// holding buffer: one write port, registered read port
// ****************************************************************
module fps_row_buffer
  import fps_pkg::*;
#(
  parameter int DEPTH = ROW_WORDS,
  parameter int WIDTH = PM_DW,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock
  input  wire logic             core_clk,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("depth must be a power of two");
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_data <= mem_r[rd_idx];
  end

endmodule

//--- design/fps_sequencer.sv
`timescale 1ns/10ps
module fps_sequencer
  import fps_pkg::*;
#(
  parameter int ROW_CYCLES  = ROW_CORE_CYCLES,
  parameter int WORD_CYCLES = WORD_CORE_CYCLES,
  parameter int PAGE_CYCLES = PAGE_CORE_CYCLES,
  parameter int BULK_CYCLES = BULK_CORE_CYCLES
) (
  // clock and resets
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  sys_rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // processor and flash array
  output logic                       cpu_stall,
  output fps_flash_cmd_s             flash_cmd,
  output fps_row_beat_s              row_beat,
  output logic                       flash_busy
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  initial begin
    if (ROW_CYCLES < ROW_WORDS + 2 || WORD_CYCLES < 1 || PAGE_CYCLES < 1 || BULK_CYCLES < 1) begin
      $error("operation cycle counts too small");
    end
    if (ROW_CYCLES >= (1 << TMR_W) || BULK_CYCLES >= (1 << TMR_W) || PAGE_CYCLES >= (1 << TMR_W)) begin
      $error("operation cycle counts exceed timer width");
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic                 trig_r;
  logic                 allow_r;
  logic                 fault_r;
  logic                 erase_r;
  logic [OPSEL_W-1:0]   opsel_r;
  fps_key_e             key_r;
  fps_state_e           state_r;
  fps_op_e              run_op_r;
  logic [TMR_W-1:0]     tmr_r;
  logic [7:0]           table_page_reg_r;
  logic [15:0]          tblofs_r;
  logic [PM_AW-1:0]     target_r;
  logic [PM_DW-1:0]     word_r;
  logic [5:0]           fill_r;
  logic [5:0]           rd_idx_r;
  logic                 stream_r;
  logic                 beat_vld_r;
  logic [5:0]           beat_idx_r;
  logic [PM_DW-1:0]     buf_rd_data;

  logic                 acc;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 mapped;
  logic                 ctrl_wr;
  logic                 key_wr;
  logic                 dat_wr;
  logic                 trig_try;
  logic                 launch;
  logic                 bad_try;
  fps_op_e              sel_op;
  logic [TMR_W-1:0]     sel_len;
  logic                 done;
  logic [PM_AW-1:0]     tbl_addr;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign pready  = (state_r == ST_IDLE);
  assign acc     = psel && penable && pready;
  assign wr_acc  = acc && pwrite;
  assign rd_acc  = acc && !pwrite;
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_KEY) || (paddr == ADDR_TABLE_PAGE_REG) ||
                   (paddr == ADDR_TBLOFS) || (paddr == ADDR_TBLDAT) || (paddr == ADDR_STATUS);
  assign pslverr = psel && penable && !mapped;
  assign ctrl_wr = wr_acc && (paddr == ADDR_CTRL);
  assign key_wr  = wr_acc && (paddr == ADDR_KEY);
  assign dat_wr  = wr_acc && (paddr == ADDR_TBLDAT);
  assign trig_try = ctrl_wr && pwdata[CTRL_TRIG_BIT];
  assign tbl_addr = {table_page_reg_r, tblofs_r};

  // ****************************************************************
  // operation decode
  // ****************************************************************
  always_comb begin
    sel_op = OP_NONE;
    if (pwdata[CTRL_ERASE_BIT]) begin
      case (pwdata[CTRL_OPSEL_LSB +: OPSEL_W])
        OPC_BULK: sel_op = OP_BULK;
        OPC_GSEG: sel_op = OP_GSEG;
        OPC_SSEG: sel_op = OP_SSEG;
        OPC_PAGE: sel_op = OP_PAGE;
        OPC_CFG:  sel_op = OP_CFG_ERASE;
        default:  sel_op = OP_NONE;
      endcase
    end else begin
      case (pwdata[CTRL_OPSEL_LSB +: OPSEL_W])
        OPC_WORD: sel_op = OP_WORD;
        OPC_ROW:  sel_op = OP_ROW;
        OPC_CFG:  sel_op = OP_CFG_PROG;
        default:  sel_op = OP_NONE;
      endcase
    end
  end

  always_comb begin
    case (sel_op)
      OP_ROW:                    sel_len = TMR_W'(ROW_CYCLES);
      OP_PAGE:                   sel_len = TMR_W'(PAGE_CYCLES);
      OP_BULK, OP_GSEG, OP_SSEG: sel_len = TMR_W'(BULK_CYCLES);
      default:                   sel_len = TMR_W'(WORD_CYCLES);
    endcase
  end

  // trigger accepted only when unlocked and allowed
  assign bad_try = trig_try && !(key_r == KEY_ARMED && pwdata[CTRL_ALLOW_BIT]);
  assign launch  = trig_try && !bad_try && (sel_op != OP_NONE);
  assign done    = (state_r == ST_RUN) && (tmr_r == TMR_W'(1));

  // ****************************************************************
  // control register: trigger also cleared by system reset, other fields only by power-on reset
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      allow_r <= 1'b0;
      erase_r <= 1'b0;
      opsel_r <= '0;
    end else if (ctrl_wr) begin
      allow_r <= pwdata[CTRL_ALLOW_BIT];
      erase_r <= pwdata[CTRL_ERASE_BIT];
      opsel_r <= pwdata[CTRL_OPSEL_LSB +: OPSEL_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_r <= 1'b0;
    end else if (launch) begin
      trig_r <= 1'b1;
    end else if (done || sys_rst) begin
      trig_r <= 1'b0;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (bad_try || (sys_rst && state_r == ST_RUN)) begin
      fault_r <= 1'b1;
    end else if (ctrl_wr) begin
      fault_r <= pwdata[CTRL_FAULT_BIT];
    end
  end

  // ****************************************************************
  // unlock sequence
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst || sys_rst) begin
      key_r <= KEY_IDLE;
    end else if (key_wr) begin
      if (key_r == KEY_HALF && pwdata[7:0] == KEY_SECOND) begin
        key_r <= KEY_ARMED;
      end else if (pwdata[7:0] == KEY_FIRST) begin
        key_r <= KEY_HALF;
      end else begin
        key_r <= KEY_IDLE;
      end
    end else if (wr_acc) begin
      key_r <= KEY_IDLE;
    end
  end

  // ****************************************************************
  // table pointer and holding buffer loading
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      table_page_reg_r <= '0;
      tblofs_r <= '0;
    end else if (wr_acc && paddr == ADDR_TABLE_PAGE_REG) begin
      table_page_reg_r <= pwdata[7:0];
    end else if (wr_acc && paddr == ADDR_TBLOFS) begin
      tblofs_r <= pwdata[15:0];
    end else if (dat_wr) begin
      tblofs_r <= tblofs_r + 16'h0002;
    end
  end

  // the first table write of a group fixes the erase or row target
  always_ff @(posedge core_clk) begin
    if (rst) begin
      target_r <= '0;
      word_r   <= '0;
    end else if (dat_wr) begin
      word_r <= pwdata[PM_DW-1:0];
      if (fill_r == 6'h00) begin
        target_r <= tbl_addr;
      end
    end
  end

  // buffer fills in sequential order and restarts after an operation
  always_ff @(posedge core_clk) begin
    if (rst || sys_rst || done) begin
      fill_r <= '0;
    end else if (dat_wr) begin
      fill_r <= fill_r + 6'h01;
    end
  end

  fps_row_buffer #(
    .DEPTH (ROW_WORDS),
    .WIDTH (PM_DW)
  ) u_buf (
    .core_clk (core_clk),
    .wr_en    (dat_wr),
    .wr_idx   (fill_r),
    .wr_data  (pwdata[PM_DW-1:0]),
    .rd_idx   (rd_idx_r),
    .rd_data  (buf_rd_data)
  );

  // ****************************************************************
  // operation timer
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst || sys_rst) begin
      state_r  <= ST_IDLE;
      tmr_r    <= '0;
      run_op_r <= OP_NONE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            state_r  <= ST_RUN;
            tmr_r    <= sel_len;
            run_op_r <= sel_op;
          end
        end
        ST_RUN: begin
          tmr_r <= tmr_r - TMR_W'(1);
          if (done) begin
            state_r  <= ST_IDLE;
            run_op_r <= OP_NONE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // flash command and row data stream
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.start <= launch;
      if (launch) begin
        flash_cmd.op   <= sel_op;
        flash_cmd.word <= word_r;
        case (sel_op)
          OP_PAGE: flash_cmd.addr <= target_r & PAGE_MASK;
          OP_ROW:  flash_cmd.addr <= target_r & ROW_MASK;
          default: flash_cmd.addr <= target_r;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || sys_rst) begin
      stream_r <= 1'b0;
      rd_idx_r <= '0;
    end else if (launch && sel_op == OP_ROW) begin
      stream_r <= 1'b1;
      rd_idx_r <= '0;
    end else if (stream_r) begin
      rd_idx_r <= rd_idx_r + 6'h01;
      if (rd_idx_r == 6'(ROW_WORDS - 1)) begin
        stream_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      beat_vld_r <= 1'b0;
      beat_idx_r <= '0;
    end else begin
      beat_vld_r <= stream_r && !sys_rst;
      beat_idx_r <= rd_idx_r;
    end
  end

  assign row_beat.valid = beat_vld_r;
  assign row_beat.idx   = beat_idx_r;
  assign row_beat.data  = buf_rd_data;

  // ****************************************************************
  // read data and status
  // ****************************************************************
  // reloaded through wait states so a stalled read returns the state at completion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !pwrite && !(penable && pready)) begin
      prdata <= '0;
      case (paddr)
        ADDR_CTRL: begin
          prdata[CTRL_TRIG_BIT]                <= trig_r && !done;
          prdata[CTRL_ALLOW_BIT]               <= allow_r;
          prdata[CTRL_FAULT_BIT]               <= fault_r;
          prdata[CTRL_ERASE_BIT]               <= erase_r;
          prdata[CTRL_OPSEL_LSB +: OPSEL_W]    <= opsel_r;
        end
        ADDR_TABLE_PAGE_REG: prdata[7:0]  <= table_page_reg_r;
        ADDR_TBLOFS: prdata[15:0] <= tblofs_r;
        ADDR_STATUS: begin
          prdata[STAT_BUSY_BIT]      <= (state_r == ST_RUN) && !done;
          prdata[STAT_KEY_LSB +: 2]  <= key_r;
          prdata[STAT_FILL_LSB +: 6] <= fill_r;
        end
        default: prdata <= '0;
      endcase
    end
  end

  assign cpu_stall  = (state_r == ST_RUN);
  assign flash_busy = trig_r;

endmodule

//--- dv/fps_sequencer_asserts.sv
`timescale 1ns/10ps
// ********************
// port checker of the sequencer
// ********************
module fps_sequencer_asserts
  import fps_pkg::*;
#(
  parameter int ROW_CYCLES  = 70
) (
  // clock and resets
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              sys_rst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // processor and flash
  input wire logic              cpu_stall,
  input wire fps_flash_cmd_s    flash_cmd,
  input wire fps_row_beat_s     row_beat,
  input wire logic              flash_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || sys_rst);

  logic [31:0] wd_q;
  logic        acc_q;
  int          run_cnt;
  logic [6:0]  beat_cnt;
  fps_op_e     op_r;

  function automatic fps_op_e op_map(input logic [4:0] k);
    case (k)
      5'h1F:   op_map = OP_BULK;
      5'h1D:   op_map = OP_GSEG;
      5'h1C:   op_map = OP_SSEG;
      5'h12:   op_map = OP_PAGE;
      5'h10:   op_map = OP_CFG_ERASE;
      5'h03:   op_map = OP_WORD;
      5'h01:   op_map = OP_ROW;
      5'h00:   op_map = OP_CFG_PROG;
      default: op_map = OP_NONE;
    endcase
  endfunction

  // write data of the previous cycle and whether it was an accepted control write
  always_ff @(posedge core_clk) begin
    wd_q  <= pwdata;
    acc_q <= psel && penable && pready && pwrite && paddr == ADDR_CTRL;
  end
  // stall length
  always_ff @(posedge core_clk) begin
    if (rst || !cpu_stall) run_cnt <= 0;
    else run_cnt <= run_cnt + 1;
  end
  // beats of the running operation
  always_ff @(posedge core_clk) begin
    if (rst || flash_cmd.start) beat_cnt <= 7'h00;
    else if (row_beat.valid) beat_cnt <= beat_cnt + 7'h01;
  end
  always_ff @(posedge core_clk) begin
    if (rst) op_r <= OP_NONE;
    else if (flash_cmd.start) op_r <= flash_cmd.op;
  end

  property p_stall_ready;
    cpu_stall |-> !pready;
  endproperty
  a_stall_ready: assert property (p_stall_ready) else $error("bus ready while stalled");
  property p_busy_stall;
    flash_busy |-> cpu_stall;
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("trigger set while idle");
  property p_launch;
    $rose(cpu_stall) |-> acc_q && wd_q[15] && wd_q[14] && flash_cmd.start && flash_cmd.op != OP_NONE
      && flash_cmd.op == op_map({wd_q[6], wd_q[3:0]});
  endproperty
  a_launch: assert property (p_launch) else $error("bad launch");
  property p_no_allow;
    psel && penable && pready && pwrite && paddr == ADDR_CTRL && !pwdata[14] |=> !cpu_stall;
  endproperty
  a_no_allow: assert property (p_no_allow) else $error("launch with allow low");
  property p_row_len;
    $fell(cpu_stall) && op_r == OP_ROW |-> run_cnt >= ROW_CYCLES - 1 && run_cnt <= ROW_CYCLES;
  endproperty
  a_row_len: assert property (p_row_len) else $error("row length wrong");
  property p_beat_order;
    row_beat.valid |-> cpu_stall && row_beat.idx == beat_cnt[5:0];
  endproperty
  a_beat_order: assert property (p_beat_order) else $error("beat out of order");
  property p_beat_total;
    $fell(cpu_stall) && op_r == OP_ROW |-> beat_cnt == 7'h40;
  endproperty
  a_beat_total: assert property (p_beat_total) else $error("beat count wrong");
  property p_key_read;
    psel && penable && !pwrite && paddr == ADDR_KEY |-> prdata == 32'h0;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key reads nonzero");
  property p_ctrl_zero;
    psel && penable && !pwrite && paddr == ADDR_CTRL |-> prdata[12:7] == 6'h00 && prdata[5:4] == 2'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused bits nonzero");
endmodule

bind fps_sequencer fps_sequencer_asserts #(
  .ROW_CYCLES(ROW_CYCLES)
) fps_sequencer_asserts_inst (
  .core_clk(core_clk), .rst(rst), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_stall(cpu_stall), .flash_cmd(flash_cmd), .row_beat(row_beat), .flash_busy(flash_busy)
);

//--- dv/fps_cpu.sv
`timescale 1ns/10ps
// ********************
// processor model: apb master
// ********************
module fps_cpu
  import fps_pkg::*;
(
  // clock
  input  wire logic              core_clk,
  // apb
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [APB_AW-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output int n);
    n = 0;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // pready moves only on rising edges: the falling edge shows what the next rising edge samples
    @(negedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines stop showing the last value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    int          n;
    xfer(1'b1, a, d, q, e, n);
  endtask

  // keys back to back, then trigger, then two idle slots
  task automatic unlock(input logic [31:0] ctrl);
    wr(ADDR_KEY, 32'h55);
    wr(ADDR_KEY, 32'hAA);
    wr(ADDR_CTRL, ctrl);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic set_target(input logic [15:0] ofs);
    wr(ADDR_TABLE_PAGE_REG, 32'h0);
    wr(ADDR_TBLOFS, {16'h0, ofs});
  endtask

  task automatic fill_row(input logic [15:0] ofs);
    set_target(ofs);
    for (int i = 0; i < 64; i++) wr(ADDR_TBLDAT, 32'h005A0000 + i);
  endtask
endmodule

//--- dv/tb_fps_sequencer.sv
`timescale 1ns/10ps
// ********************
// bench of the flash sequencer
// ********************
module tb_fps_sequencer
  import fps_pkg::*;
;
  localparam int ROW = 70;
  logic           core_clk;
  logic           rst = 1'b1;
  logic           sys_rst = 1'b0;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           cpu_stall;
  fps_flash_cmd_s flash_cmd;
  fps_row_beat_s  row_beat;
  logic           flash_busy;
  int             fail_count = 0;
  int             samples_checked = 0;
  int             beat_i = 0;
  logic           beat_on = 1'b0;
  logic [23:0]    cmd_addr = 24'h0;

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  fps_cpu fps_cpu_inst (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fps_sequencer #(.ROW_CYCLES(ROW), .WORD_CYCLES(8), .PAGE_CYCLES(8), .BULK_CYCLES(8)) fps_sequencer_inst (
    .core_clk(core_clk), .rst(rst), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_stall(cpu_stall), .flash_cmd(flash_cmd), .row_beat(row_beat), .flash_busy(flash_busy));

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e, output int n);
    fps_cpu_inst.xfer(1'b0, a, 32'h0, q, e, n);
  endtask

  // reads control; a launched operation shows as wait states
  task automatic expect_ctrl(input logic [31:0] exp, input logic go);
    logic [31:0] q;
    logic        e;
    int          n;
    rd(ADDR_CTRL, q, e, n);
    check(q, exp);
    check({31'h0, n > 0}, {31'h0, go});
  endtask

  function automatic logic code_ok(input logic [4:0] k);
    code_ok = k[4] ? (k[3:0] inside {4'hF, 4'hD, 4'hC, 4'h2, 4'h0}) : (k[3:0] inside {4'h3, 4'h1, 4'h0});
  endfunction

  always @(posedge core_clk) begin
    if (flash_cmd.start === 1'b1) cmd_addr = flash_cmd.addr;
    if (beat_on && row_beat.valid === 1'b1) begin
      check({8'h00, row_beat.data}, 32'h005A0000 + beat_i);
      beat_i++;
    end
  end

  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    int          n;
    expect_ctrl(32'h0, 1'b0);
    rd(8'h18, q, e, n);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_row;
    logic [31:0] q;
    logic        e;
    int          n;
    fps_cpu_inst.set_target(16'h6010);
    fps_cpu_inst.wr(ADDR_TBLDAT, 32'h0);
    fps_cpu_inst.wr(ADDR_CTRL, 32'h4042);
    fps_cpu_inst.unlock(32'hC042);
    expect_ctrl(32'h4042, 1'b1);
    check({8'h00, cmd_addr}, 32'h6000);
    beat_i = 0;
    beat_on = 1'b1;
    fps_cpu_inst.fill_row(16'h6000);
    fps_cpu_inst.unlock(32'hC001);
    rd(ADDR_CTRL, q, e, n);
    check(q, 32'h4001);
    check({31'h0, n > ROW - 10}, 32'h1);
    check(beat_i, 32'd64);
    beat_on = 1'b0;
    rd(ADDR_KEY, q, e, n);
    check(q, 32'h0);
    $display("test row done");
  endtask

  task automatic t_faults;
    fps_cpu_inst.wr(ADDR_CTRL, 32'hC001);
    expect_ctrl(32'h6001, 1'b0);
    fps_cpu_inst.wr(ADDR_CTRL, 32'h4001);
    expect_ctrl(32'h4001, 1'b0);
    fps_cpu_inst.wr(ADDR_KEY, 32'h55);
    fps_cpu_inst.wr(ADDR_TABLE_PAGE_REG, 32'h0);
    fps_cpu_inst.wr(ADDR_KEY, 32'hAA);
    fps_cpu_inst.wr(ADDR_CTRL, 32'hC001);
    expect_ctrl(32'h6001, 1'b0);
    fps_cpu_inst.unlock(32'h8001);
    expect_ctrl(32'h2001, 1'b0);
    $display("test faults done");
  endtask

  task automatic t_codes;
    logic [4:0] kk;
    for (int k = 0; k < 32; k++) begin
      kk = k[4:0];
      fps_cpu_inst.unlock({16'h0, 9'h180, kk[4], 2'b00, kk[3:0]});
      expect_ctrl({16'h0, 9'h080, kk[4], 2'b00, kk[3:0]}, code_ok(kk));
    end
    $display("test codes done");
  endtask

  task automatic t_resets;
    fps_cpu_inst.unlock(32'hC04F);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    expect_ctrl(32'h604F, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    expect_ctrl(32'h0, 1'b0);
    $display("test resets done");
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_row;
    t_faults;
    t_codes;
    t_resets;
    finish_test;
  end

  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
endmodule
